// ### hdl/tmr_timer16.sv
// 16-bit timer with input capture, two compare channels and byte register port
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - with filter on, capture level changes only after four equal samples
// - edge select zero captures on falling edge, one on rising edge
// - capture copies counter into capture register and sets capture flag
// - modes using capture register as top disable capture events
// - clock select picks stop, divide 1/8/64/256/1024, or count pin edge
// - count pin edges advance counter even when pin is an output
// - force bits in non-pwm modes apply a compare match to the output
// - force strobes raise no flag, never clear counter, read zero
// - counter accessed as two bytes through shared high-byte latch
// - counter write suppresses compare match on the next timer tick
// - compare registers continuously compared, matches drive flags and outputs
// - capture source is pin or comparator; capture register may be top
// - mask bits: capture 5, compare b 2, compare a 1, overflow 0
// - request raised only when enable, global enable and flag all set
// - unused mask bits 7,6,4,3 read zero
// - flags clear on service acknowledge or by writing one
// - compare flag set on tick after equality, never by force
// - waveform mode chooses count sequence, top source and wave type
module tmr_timer16 (
	// clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_n_in,
	// cpu byte port
	input  wire tmr_pkg::tmr_cpu_req_t cpu_in,
	output logic [7:0]                 cpu_rdata_out,
	// interrupt handshake
	input  wire logic                  gie_in,
	input  wire logic [3:0]            irq_ack_in,
	output logic [3:0]                 irq_out,
	// pins and comparator
	input  wire logic                  capture_input_pin_in,
	input  wire logic                  comparator_out_in,
	input  wire logic                  capture_from_comparator_in,
	input  wire logic                  count_input_pin_in,
	output logic                       wave_out_a_out,
	output logic                       wave_out_b_out
);

	tmr_pkg::tmr_state_t s_q;
	tmr_pkg::tmr_state_t s_d;

	// ==================================================
	// compare output unit
	function automatic logic wave_next(
		input logic       w,
		input logic [1:0] com,
		input logic       m,
		input logic       f,
		input logic       bot,
		input logic       tog_ok,
		input logic       non_pwm,
		input logic       fast,
		input logic       down
	);
		logic r;
		r = w;
		if (non_pwm) begin
			if (m | f) begin
				case (com)
					2'b01:   r = ~w;
					2'b10:   r = 1'b0;
					2'b11:   r = 1'b1;
					default: r = w;
				endcase
			end
		end else if (com[1]) begin
			if (m)
				r = (fast | ~down) ? com[0] : ~com[0];
			// bottom update last: a match at top is overridden here
			if (fast & bot)
				r = ~com[0];
		end else if (com[0] & tog_ok & m) begin
			r = ~w;
		end
		return r;
	endfunction : wave_next

	// ==================================================
	// next state
	tmr_pkg::tmr_wgm_t wgm;
	logic [2:0]  cs;
	logic [15:0] top;
	logic        cap_top;
	logic        non_pwm;
	logic        fast;
	logic        tog_a;
	logic        tick;
	logic        cap_src;
	logic        cap_lvl;
	logic        cap_ev;
	logic        at_top;
	logic        match_a;
	logic        match_b;
	logic        bot;
	logic        force_a;
	logic        force_b;
	logic [7:0]  setv;
	logic [7:0]  clrv;
	logic        wr;

	always_comb begin
		s_d = s_q;
		wgm = tmr_pkg::tmr_wgm_t'({s_q.ctrl_b[4:3], s_q.ctrl_a[1:0]});
		cs = s_q.ctrl_b[2:0];
		top = tmr_pkg::TOP_MAX;
		cap_top = 1'b0;
		non_pwm = 1'b0;
		fast = 1'b0;
		tog_a = 1'b0;
		setv = tmr_pkg::RESET_BYTE;
		clrv = tmr_pkg::RESET_BYTE;
		wr = cpu_in.wr;
		case (wgm)
			tmr_pkg::WM_NORMAL:   non_pwm = 1'b1;
			tmr_pkg::WM_PC8:      top = tmr_pkg::TOP_8BIT;
			tmr_pkg::WM_PC9:      top = tmr_pkg::TOP_9BIT;
			tmr_pkg::WM_PC10:     top = tmr_pkg::TOP_10BIT;
			tmr_pkg::WM_CTC_A: begin
				top = s_q.cmpa;
				non_pwm = 1'b1;
			end
			tmr_pkg::WM_FAST8: begin
				top = tmr_pkg::TOP_8BIT;
				fast = 1'b1;
			end
			tmr_pkg::WM_FAST9: begin
				top = tmr_pkg::TOP_9BIT;
				fast = 1'b1;
			end
			tmr_pkg::WM_FAST10: begin
				top = tmr_pkg::TOP_10BIT;
				fast = 1'b1;
			end
			tmr_pkg::WM_PFC_CAP,
			tmr_pkg::WM_PC_CAP: begin
				top = s_q.cap;
				cap_top = 1'b1;
			end
			tmr_pkg::WM_PFC_A,
			tmr_pkg::WM_PC_A: begin
				top = s_q.cmpa;
				tog_a = 1'b1;
			end
			tmr_pkg::WM_CTC_CAP: begin
				top = s_q.cap;
				cap_top = 1'b1;
				non_pwm = 1'b1;
			end
			tmr_pkg::WM_FAST_CAP: begin
				top = s_q.cap;
				cap_top = 1'b1;
				fast = 1'b1;
			end
			tmr_pkg::WM_FAST_A: begin
				top = s_q.cmpa;
				fast = 1'b1;
				tog_a = 1'b1;
			end
			default:              non_pwm = 1'b1;
		endcase

		// pin synchronisers; pins may toggle at any time
		s_d.cap_s1 = capture_input_pin_in;
		s_d.cap_s2 = s_q.cap_s1;
		s_d.acmp_s1 = comparator_out_in;
		s_d.acmp_s2 = s_q.acmp_s1;
		s_d.t_s1 = count_input_pin_in;
		s_d.t_s2 = s_q.t_s1;
		s_d.t_prev = s_q.t_s2;

		// free-running prescaler
		s_d.presc = s_q.presc + 10'h001;
		case (cs)
			tmr_pkg::CS_DIV1:     tick = 1'b1;
			tmr_pkg::CS_DIV8:     tick = &s_q.presc[tmr_pkg::TAP8-1:0];
			tmr_pkg::CS_DIV64:    tick = &s_q.presc[tmr_pkg::TAP64-1:0];
			tmr_pkg::CS_DIV256:   tick = &s_q.presc[tmr_pkg::TAP256-1:0];
			tmr_pkg::CS_DIV1024:  tick = &s_q.presc[tmr_pkg::TAP1024-1:0];
			tmr_pkg::CS_EXT_FALL: tick = s_q.t_prev & ~s_q.t_s2;
			tmr_pkg::CS_EXT_RISE: tick = s_q.t_s2 & ~s_q.t_prev;
			default:              tick = 1'b0;
		endcase

		// capture path
		cap_src = capture_from_comparator_in ? s_q.acmp_s2 : s_q.cap_s2;
		s_d.hist = {s_q.hist[tmr_pkg::FILT_SAMPLES-2:0], cap_src};
		if (&s_d.hist)
			s_d.filt = 1'b1;
		else if (~|s_d.hist)
			s_d.filt = 1'b0;
		cap_lvl = s_q.ctrl_b[tmr_pkg::B_NOISE] ? s_q.filt : cap_src;
		s_d.cap_prev = cap_lvl;
		cap_ev = s_q.ctrl_b[tmr_pkg::B_EDGE] ? (cap_lvl & ~s_q.cap_prev)
			: (~cap_lvl & s_q.cap_prev);
		cap_ev = cap_ev & ~cap_top;
		if (cap_ev) begin
			s_d.cap = s_q.cnt;
			setv[tmr_pkg::B_CAP] = 1'b1;
		end

		// counter and compare
		at_top = (s_q.cnt == top);
		match_a = tick & ~s_q.block & (s_q.cnt == s_q.cmpa);
		match_b = tick & ~s_q.block & (s_q.cnt == s_q.cmpb);
		bot = tick & at_top;
		setv[tmr_pkg::B_CMPA] = match_a;
		setv[tmr_pkg::B_CMPB] = match_b;
		if (tick) begin
			s_d.block = 1'b0;
			if (cap_top & at_top)
				setv[tmr_pkg::B_CAP] = 1'b1;
			if (!non_pwm && !fast) begin
				if (!s_q.dir_down) begin
					if (at_top) begin
						s_d.dir_down = 1'b1;
						s_d.cnt = s_q.cnt - 16'h0001;
					end else begin
						s_d.cnt = s_q.cnt + 16'h0001;
					end
				end else if (s_q.cnt == tmr_pkg::BOTTOM) begin
					s_d.dir_down = 1'b0;
					s_d.cnt = s_q.cnt + 16'h0001;
					setv[tmr_pkg::B_OVF] = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 16'h0001;
				end
			end else begin
				s_d.dir_down = 1'b0;
				s_d.cnt = at_top ? tmr_pkg::BOTTOM : s_q.cnt + 16'h0001;
				if (fast ? at_top : (s_q.cnt == tmr_pkg::TOP_MAX))
					setv[tmr_pkg::B_OVF] = 1'b1;
			end
		end

		// force strobes touch only the outputs, never flags or counter
		force_a = wr & (cpu_in.addr == tmr_pkg::OFS_CTRL_C) & cpu_in.wdata[tmr_pkg::B_FORCE_A];
		force_b = wr & (cpu_in.addr == tmr_pkg::OFS_CTRL_C) & cpu_in.wdata[tmr_pkg::B_FORCE_B];
		s_d.wave_a = wave_next(s_q.wave_a, s_q.ctrl_a[7:6], match_a, force_a, bot,
			tog_a, non_pwm, fast, s_q.dir_down);
		s_d.wave_b = wave_next(s_q.wave_b, s_q.ctrl_a[5:4], match_b, force_b, bot,
			1'b0, non_pwm, fast, s_q.dir_down);

		// cpu writes
		if (wr) begin
			case (cpu_in.addr)
				tmr_pkg::OFS_FLAGS:  clrv = cpu_in.wdata & tmr_pkg::IRQ_BITS;
				tmr_pkg::OFS_MASK:   s_d.mask = cpu_in.wdata & tmr_pkg::IRQ_BITS;
				tmr_pkg::OFS_CTRL_A: s_d.ctrl_a = cpu_in.wdata;
				tmr_pkg::OFS_CTRL_B: s_d.ctrl_b = cpu_in.wdata & tmr_pkg::CTRL_B_WMASK;
				tmr_pkg::OFS_CNT_L: begin
					s_d.cnt = {s_q.temp, cpu_in.wdata};
					s_d.block = 1'b1;
				end
				tmr_pkg::OFS_CAP_L:  s_d.cap = {s_q.temp, cpu_in.wdata};
				tmr_pkg::OFS_CMPA_L: s_d.cmpa = {s_q.temp, cpu_in.wdata};
				tmr_pkg::OFS_CMPB_L: s_d.cmpb = {s_q.temp, cpu_in.wdata};
				tmr_pkg::OFS_CNT_H,
				tmr_pkg::OFS_CAP_H,
				tmr_pkg::OFS_CMPA_H,
				tmr_pkg::OFS_CMPB_H: s_d.temp = cpu_in.wdata;
				default:             s_d.temp = s_q.temp;
			endcase
		end

		// flags: a set in the same cycle beats the clear
		clrv[tmr_pkg::B_CAP]  = clrv[tmr_pkg::B_CAP] | irq_ack_in[3];
		clrv[tmr_pkg::B_CMPB] = clrv[tmr_pkg::B_CMPB] | irq_ack_in[2];
		clrv[tmr_pkg::B_CMPA] = clrv[tmr_pkg::B_CMPA] | irq_ack_in[1];
		clrv[tmr_pkg::B_OVF]  = clrv[tmr_pkg::B_OVF] | irq_ack_in[0];
		s_d.flags = ((s_q.flags & ~clrv) | setv) & tmr_pkg::IRQ_BITS;

		// cpu reads, answered on the following cycle
		if (cpu_in.rd) begin
			case (cpu_in.addr)
				tmr_pkg::OFS_FLAGS:  s_d.rdata = s_q.flags;
				tmr_pkg::OFS_MASK:   s_d.rdata = s_q.mask;
				tmr_pkg::OFS_CTRL_A: s_d.rdata = s_q.ctrl_a;
				tmr_pkg::OFS_CTRL_B: s_d.rdata = s_q.ctrl_b;
				tmr_pkg::OFS_CNT_L: begin
					s_d.rdata = s_q.cnt[7:0];
					s_d.temp = s_q.cnt[15:8];
				end
				tmr_pkg::OFS_CAP_L: begin
					s_d.rdata = s_q.cap[7:0];
					s_d.temp = s_q.cap[15:8];
				end
				tmr_pkg::OFS_CNT_H,
				tmr_pkg::OFS_CAP_H:  s_d.rdata = s_q.temp;
				tmr_pkg::OFS_CMPA_L: s_d.rdata = s_q.cmpa[7:0];
				tmr_pkg::OFS_CMPA_H: s_d.rdata = s_q.cmpa[15:8];
				tmr_pkg::OFS_CMPB_L: s_d.rdata = s_q.cmpb[7:0];
				tmr_pkg::OFS_CMPB_H: s_d.rdata = s_q.cmpb[15:8];
				default:             s_d.rdata = tmr_pkg::RESET_BYTE;
			endcase
		end

		// requests follow the registered flags
		s_d.irq = {s_q.flags[tmr_pkg::B_CAP], s_q.flags[tmr_pkg::B_CMPB],
			s_q.flags[tmr_pkg::B_CMPA], s_q.flags[tmr_pkg::B_OVF]}
			& {s_q.mask[tmr_pkg::B_CAP], s_q.mask[tmr_pkg::B_CMPB],
			s_q.mask[tmr_pkg::B_CMPA], s_q.mask[tmr_pkg::B_OVF]}
			& {4{gie_in}};
	end

	// ==================================================
	// state register
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign cpu_rdata_out  = s_q.rdata;
	assign irq_out        = s_q.irq;
	assign wave_out_a_out = s_q.wave_a;
	assign wave_out_b_out = s_q.wave_b;

endmodule : tmr_timer16
`default_nettype wire

// ### shared/tmr_pkg.sv
// constants, register map and carrier types of the 16-bit capture/compare timer
package tmr_pkg;

	// ==================================================
	// register offsets (byte addresses on the i/o port)
	localparam logic [7:0] OFS_FLAGS  = 8'h36;
	localparam logic [7:0] OFS_MASK   = 8'h6f;
	localparam logic [7:0] OFS_CTRL_A = 8'h80;
	localparam logic [7:0] OFS_CTRL_B = 8'h81;
	localparam logic [7:0] OFS_CTRL_C = 8'h82;
	localparam logic [7:0] OFS_CNT_L  = 8'h84;
	localparam logic [7:0] OFS_CNT_H  = 8'h85;
	localparam logic [7:0] OFS_CAP_L  = 8'h86;
	localparam logic [7:0] OFS_CAP_H  = 8'h87;
	localparam logic [7:0] OFS_CMPA_L = 8'h88;
	localparam logic [7:0] OFS_CMPA_H = 8'h89;
	localparam logic [7:0] OFS_CMPB_L = 8'h8a;
	localparam logic [7:0] OFS_CMPB_H = 8'h8b;

	// ==================================================
	// field positions and masks
	localparam int B_CAP      = 5;
	localparam int B_CMPB     = 2;
	localparam int B_CMPA     = 1;
	localparam int B_OVF      = 0;
	localparam logic [7:0] IRQ_BITS   = 8'h27;
	localparam int B_NOISE    = 7;
	localparam int B_EDGE     = 6;
	localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
	localparam int B_FORCE_A  = 7;
	localparam int B_FORCE_B  = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ==================================================
	// clock select codes and prescaler taps
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_W  = 10;
	localparam int TAP8     = 3;
	localparam int TAP64    = 6;
	localparam int TAP256   = 8;
	localparam int TAP1024  = 10;

	// ==================================================
	// counter limits and filter length
	localparam logic [15:0] TOP_MAX   = 16'hffff;
	localparam logic [15:0] TOP_8BIT  = 16'h00ff;
	localparam logic [15:0] TOP_9BIT  = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] BOTTOM    = 16'h0000;
	localparam int FILT_SAMPLES = 4;

	// ==================================================
	// waveform modes
	typedef enum logic [3:0] {
		WM_NORMAL    = 4'b0000,
		WM_PC8       = 4'b0001,
		WM_PC9       = 4'b0010,
		WM_PC10      = 4'b0011,
		WM_CTC_A     = 4'b0100,
		WM_FAST8     = 4'b0101,
		WM_FAST9     = 4'b0110,
		WM_FAST10    = 4'b0111,
		WM_PFC_CAP   = 4'b1000,
		WM_PFC_A     = 4'b1001,
		WM_PC_CAP    = 4'b1010,
		WM_PC_A      = 4'b1011,
		WM_CTC_CAP   = 4'b1100,
		WM_RESERVED  = 4'b1101,
		WM_FAST_CAP  = 4'b1110,
		WM_FAST_A    = 4'b1111
	} tmr_wgm_t;

	// ==================================================
	// carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmr_cpu_req_t;

	typedef struct packed {
		logic [7:0]         ctrl_a;
		logic [7:0]         ctrl_b;
		logic [7:0]         mask;
		logic [7:0]         flags;
		logic [15:0]        cnt;
		logic [15:0]        cmpa;
		logic [15:0]        cmpb;
		logic [15:0]        cap;
		logic [7:0]         temp;
		logic [PRESC_W-1:0] presc;
		logic               dir_down;
		logic               block;
		logic               cap_s1;
		logic               cap_s2;
		logic               acmp_s1;
		logic               acmp_s2;
		logic               t_s1;
		logic               t_s2;
		logic               t_prev;
		logic [FILT_SAMPLES-1:0] hist;
		logic               filt;
		logic               cap_prev;
		logic               wave_a;
		logic               wave_b;
		logic [7:0]         rdata;
		logic [3:0]         irq;
	} tmr_state_t;

endpackage : tmr_pkg

// ### tb/tb.sv
// self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                  clk_sys_in;
	logic                  rst_n_in;
	tmr_pkg::tmr_cpu_req_t cpu_in;
	logic [7:0]            cpu_rdata_out;
	logic                  gie_in;
	logic [3:0]            irq_ack_in;
	logic [3:0]            irq_out;
	logic                  cap_pin, cmp_pin, cnt_pin, from_cmp, wave_a, wave_b;
	logic [15:0]           v;
	int                    num_errors = 0;
	int                    checked = 0;
	int                    cycles = 0;
	tmr_timer16 u_tmr_timer16 (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cpu_in(cpu_in),
		.cpu_rdata_out(cpu_rdata_out), .gie_in(gie_in), .irq_ack_in(irq_ack_in), .irq_out(irq_out),
		.capture_input_pin_in(cap_pin), .comparator_out_in(cmp_pin), .capture_from_comparator_in(from_cmp),
		.count_input_pin_in(cnt_pin), .wave_out_a_out(wave_a), .wave_out_b_out(wave_b));
	tmr_pin_model u_tmr_pin_model (.clk_sys_in(clk_sys_in), .capture_pin_out(cap_pin),
		.comparator_out(cmp_pin), .count_pin_out(cnt_pin));
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	// ========
	// helpers
	task automatic summarize();
		if (num_errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		cpu_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_in);
		cpu_in <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		cpu_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_in);
		cpu_in <= '0;
		#1 d = cpu_rdata_out;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask : rc
	// high byte first so the low write commits all 16 bits
	task automatic w16(input logic [7:0] lo, input logic [15:0] d);
		wr(lo + 8'h01, d[15:8]);
		wr(lo, d[7:0]);
	endtask : w16
	task automatic r16(input logic [7:0] lo, output logic [15:0] d);
		logic [7:0] l, h;
		rd(lo, l);
		rd(lo + 8'h01, h);
		d = {h, l};
	endtask : r16
	// ========
	// scenarios
	task automatic t_regs();
		rc(tmr_pkg::OFS_CTRL_B, 8'h00);
		wr(tmr_pkg::OFS_MASK, 8'hff);
		rc(tmr_pkg::OFS_MASK, 8'h27);
		wr(tmr_pkg::OFS_CTRL_B, 8'hc0);
		rc(tmr_pkg::OFS_CTRL_B, 8'hc0);
		rc(8'h00, 8'h00);
		wr(tmr_pkg::OFS_CTRL_B, 8'h00);
	endtask : t_regs
	task automatic t_word();
		w16(tmr_pkg::OFS_CNT_L, 16'h1234);
		r16(tmr_pkg::OFS_CNT_L, v);
		chk(v, 16'h1234);
		wr(tmr_pkg::OFS_CMPB_H, 8'h5a);
		rc(tmr_pkg::OFS_CNT_L, 8'h34);
		wr(tmr_pkg::OFS_CMPB_L, 8'h01);
		r16(tmr_pkg::OFS_CMPB_L, v);
		chk(v, 16'h1201);
	endtask : t_word
	task automatic t_force();
		wr(tmr_pkg::OFS_MASK, 8'h02);
		wr(tmr_pkg::OFS_CTRL_A, 8'h70);
		wr(tmr_pkg::OFS_CTRL_C, 8'hc0);
		tick(2);
		chk(16'({wave_a, wave_b}), 16'h0003);
		wr(tmr_pkg::OFS_CTRL_C, 8'hc0);
		tick(2);
		chk(16'({wave_a, wave_b}), 16'h0001);
		chk(16'(irq_out), 16'h0000);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
		rc(tmr_pkg::OFS_CTRL_C, 8'h00);
		wr(tmr_pkg::OFS_CTRL_A, 8'h00);
	endtask : t_force
	task automatic t_match();
		w16(tmr_pkg::OFS_CMPA_L, 16'h0010);
		w16(tmr_pkg::OFS_CNT_L, 16'h0010);
		wr(tmr_pkg::OFS_CTRL_B, 8'h01);
		wr(tmr_pkg::OFS_CTRL_B, 8'h00);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
		w16(tmr_pkg::OFS_CNT_L, 16'h000c);
		wr(tmr_pkg::OFS_CTRL_B, 8'h01);
		tick(8);
		wr(tmr_pkg::OFS_CTRL_B, 8'h00);
		rc(tmr_pkg::OFS_FLAGS, 8'h02);
		chk(16'(irq_out), 16'h0002);
		gie_in <= 1'b0;
		tick(2);
		chk(16'(irq_out), 16'h0000);
		wr(tmr_pkg::OFS_FLAGS, 8'h02);
		gie_in <= 1'b1;
		tick(2);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
	endtask : t_match
	task automatic t_presc();
		int dv[4] = '{8, 64, 256, 1024};
		for (int k = 0; k < 4; k++) begin
			w16(tmr_pkg::OFS_CNT_L, 16'h0000);
			wr(tmr_pkg::OFS_CTRL_B, 8'(k + 2));
			repeat (4 * dv[k] - 2) @(posedge clk_sys_in);
			wr(tmr_pkg::OFS_CTRL_B, 8'h00);
			r16(tmr_pkg::OFS_CNT_L, v);
			checked++;
			if ((v >= 16'h0003 && v <= 16'h0005) !== 1'b1) begin
				num_errors++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, v, 16'h0004);
			end
		end
	endtask : t_presc
	task automatic t_ext();
		w16(tmr_pkg::OFS_CNT_L, 16'h0000);
		wr(tmr_pkg::OFS_CTRL_B, 8'h07);
		u_tmr_pin_model.count_pulses(5);
		wr(tmr_pkg::OFS_CTRL_B, 8'h06);
		u_tmr_pin_model.count_pulses(3);
		tick(6);
		wr(tmr_pkg::OFS_CTRL_B, 8'h00);
		r16(tmr_pkg::OFS_CNT_L, v);
		chk(v, 16'h0008);
	endtask : t_ext
	task automatic t_cap();
		wr(tmr_pkg::OFS_MASK, 8'h20);
		w16(tmr_pkg::OFS_CNT_L, 16'h0abc);
		wr(tmr_pkg::OFS_CTRL_B, 8'h40);
		u_tmr_pin_model.drive_capture(1'b1, 8, 1'b0);
		chk(16'(irq_out), 16'h0008);
		r16(tmr_pkg::OFS_CAP_L, v);
		chk(v, 16'h0abc);
		irq_ack_in <= 4'h8;
		tick(1);
		irq_ack_in <= 4'h0;
		u_tmr_pin_model.drive_capture(1'b0, 8, 1'b0);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
		wr(tmr_pkg::OFS_CTRL_B, 8'hc0);
		u_tmr_pin_model.drive_capture(1'b1, 2, 1'b0);
		u_tmr_pin_model.drive_capture(1'b0, 8, 1'b0);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
		wr(tmr_pkg::OFS_CTRL_B, 8'h00);
		w16(tmr_pkg::OFS_CNT_L, 16'h0123);
		u_tmr_pin_model.drive_capture(1'b1, 8, 1'b0);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
		u_tmr_pin_model.drive_capture(1'b0, 8, 1'b0);
		r16(tmr_pkg::OFS_CAP_L, v);
		chk(v, 16'h0123);
		wr(tmr_pkg::OFS_FLAGS, 8'h20);
		from_cmp <= 1'b1;
		wr(tmr_pkg::OFS_CTRL_B, 8'h40);
		w16(tmr_pkg::OFS_CNT_L, 16'h0777);
		u_tmr_pin_model.drive_capture(1'b1, 8, 1'b1);
		r16(tmr_pkg::OFS_CAP_L, v);
		chk(v, 16'h0777);
		wr(tmr_pkg::OFS_FLAGS, 8'h20);
		from_cmp <= 1'b0;
		wr(tmr_pkg::OFS_CTRL_B, 8'h58);
		u_tmr_pin_model.drive_capture(1'b1, 8, 1'b0);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
	endtask : t_cap
	// overflow at max, compare b flag and request, toggle on a real match
	task automatic t_ovf();
		wr(tmr_pkg::OFS_MASK, 8'h05);
		wr(tmr_pkg::OFS_CTRL_A, 8'h10);
		w16(tmr_pkg::OFS_CMPB_L, 16'h0002);
		w16(tmr_pkg::OFS_CNT_L, 16'hfffe);
		wr(tmr_pkg::OFS_CTRL_B, 8'h01);
		tick(4);
		wr(tmr_pkg::OFS_CTRL_B, 8'h00);
		rc(tmr_pkg::OFS_FLAGS, 8'h05);
		chk(16'(irq_out), 16'h0005);
		chk(16'(wave_b), 16'h0000);
		wr(tmr_pkg::OFS_FLAGS, 8'h05);
		rc(tmr_pkg::OFS_FLAGS, 8'h00);
		wr(tmr_pkg::OFS_CTRL_A, 8'h00);
	endtask : t_ovf
	// ========
	// main sequence and hang guard
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		cpu_in = '0;
		gie_in = 1'b0;
		irq_ack_in = 4'h0;
		from_cmp = 1'b0;
		rst_n_in = 1'b0;
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		gie_in <= 1'b1;
		t_regs();
		t_word();
		t_force();
		t_match();
		t_presc();
		t_ext();
		t_cap();
		t_ovf();
		summarize();
	end
endmodule : tb
`default_nettype wire

// ### tb/tmr_pin_model.sv
// model of the capture, comparator and count pins
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
	// clock
	input  wire logic clk_sys_in,
	// pins toward the timer
	output logic      capture_pin_out,
	output logic      comparator_out,
	output logic      count_pin_out
);
	initial begin
		capture_pin_out = 1'b0;
		comparator_out = 1'b0;
		count_pin_out = 1'b0;
	end
	// levels held several clocks: the sampler misses pulses shorter than one clock
	task automatic count_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys_in);
			count_pin_out <= 1'b1;
			repeat (3) @(posedge clk_sys_in);
			count_pin_out <= 1'b0;
			repeat (2) @(posedge clk_sys_in);
		end
	endtask : count_pulses
	task automatic drive_capture(input logic v, input int hold, input logic via_cmp);
		@(posedge clk_sys_in);
		if (via_cmp) begin
			comparator_out <= v;
		end else begin
			capture_pin_out <= v;
		end
		repeat (hold) @(posedge clk_sys_in);
	endtask : drive_capture
endmodule : tmr_pin_model
`default_nettype wire

// ### tb/tmr_timer16_sva.sv
// port assertions for the 16-bit capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_sva (
	// clock and reset
	input wire logic                  clk_sys_in,
	input wire logic                  rst_n_in,
	// cpu port
	input wire tmr_pkg::tmr_cpu_req_t cpu_in,
	input wire logic [7:0]            cpu_rdata_out,
	// interrupts
	input wire logic                  gie_in,
	input wire logic [3:0]            irq_ack_in,
	input wire logic [3:0]            irq_out,
	// pins
	input wire logic                  capture_input_pin_in,
	input wire logic                  comparator_out_in,
	input wire logic                  capture_from_comparator_in,
	input wire logic                  count_input_pin_in,
	input wire logic                  wave_out_a_out,
	input wire logic                  wave_out_b_out
);
	// ========
	// mask shadow, needed to judge gating
	logic [7:0] mask_q;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask_q <= 8'h00;
		end else if (cpu_in.wr && cpu_in.addr == tmr_pkg::OFS_MASK) begin
			mask_q <= cpu_in.wdata & tmr_pkg::IRQ_BITS;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// ========
	// assertions
	AST_IRQ_GIE: assert property ((|irq_out) |-> $past(gie_in))
		else $error("request without global enable");
	AST_IRQ_MASK_A: assert property (irq_out[1] |-> $past(mask_q[1]))
		else $error("compare a request while masked");
	AST_IRQ_MASK_CAP: assert property (irq_out[3] |-> $past(mask_q[5]))
		else $error("capture request while masked");
	AST_CTRLC_ZERO: assert property ($past(cpu_in.rd) && $past(cpu_in.addr) == tmr_pkg::OFS_CTRL_C |-> cpu_rdata_out == 8'h00)
		else $error("force bits read nonzero");
	AST_MASK_RSVD: assert property ($past(cpu_in.rd) && $past(cpu_in.addr) == tmr_pkg::OFS_MASK |-> (cpu_rdata_out & 8'hd8) == 8'h00)
		else $error("unused mask bits read nonzero");
	AST_FLAGS_RSVD: assert property ($past(cpu_in.rd) && $past(cpu_in.addr) == tmr_pkg::OFS_FLAGS |-> (cpu_rdata_out & 8'hd8) == 8'h00)
		else $error("unused flag bits read nonzero");
	AST_CTRLB_BIT5: assert property ($past(cpu_in.rd) && $past(cpu_in.addr) == tmr_pkg::OFS_CTRL_B |-> !cpu_rdata_out[5])
		else $error("reserved control bit reads one");
	AST_RDATA_HOLD: assert property (!$past(cpu_in.rd) |-> $stable(cpu_rdata_out))
		else $error("read data moved without a read");
	AST_ACK_CAP: assert property (irq_ack_in[3] |-> ##2 !irq_out[3] [*2])
		else $error("capture request survived acknowledge");
	AST_W1C_A: assert property (cpu_in.wr && cpu_in.addr == tmr_pkg::OFS_FLAGS && cpu_in.wdata[1] |-> ##2 !irq_out[1])
		else $error("compare a request survived clear");
	cover property ($rose(irq_out[1]));
	cover property ($rose(irq_out[3]));
	cover property ($rose(wave_out_a_out));
	cover property ($rose(irq_out[0]));
endmodule : tmr_timer16_sva
bind tmr_timer16 tmr_timer16_sva u_tmr_timer16_sva (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cpu_in(cpu_in),
	.cpu_rdata_out(cpu_rdata_out), .gie_in(gie_in), .irq_ack_in(irq_ack_in), .irq_out(irq_out),
	.capture_input_pin_in(capture_input_pin_in), .comparator_out_in(comparator_out_in),
	.capture_from_comparator_in(capture_from_comparator_in), .count_input_pin_in(count_input_pin_in),
	.wave_out_a_out(wave_out_a_out), .wave_out_b_out(wave_out_b_out));
`default_nettype wire
